// ---- verification/cmd_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// controller model: word now, parity one cycle later
// ***************************************************
module cmd_ctrl_model (
  // clock
  input  wire logic                             i_clk_sys,
  // what the bench wants sent
  input  wire logic [cmd_buffer_pkg::CMD_W-1:0] i_word,
  input  wire logic [1:0]                       i_sel_n,
  input  wire logic                             i_bad,
  // lines toward the buffer
  output logic [cmd_buffer_pkg::CMD_W-1:0]      o_cmd,
  output logic                                  o_sel0_n,
  output logic                                  o_sel1_n,
  output var logic                              o_par
);
  logic hold_q;  // parity owed for the word taken at the last rising edge

  // word and selects pass through; the bench moves them at falling edges
  assign o_cmd    = i_word;
  assign o_sel0_n = i_sel_n[0];
  assign o_sel1_n = i_sel_n[1];

  initial o_par = 1'b0;
  // even parity over word plus bit; i_bad flips it to inject a fault
  always @(posedge i_clk_sys) hold_q <= ^i_word ^ i_bad;
  // bit lags its word by one cycle, launched at the falling edge
  always @(negedge i_clk_sys) o_par <= hold_q;
endmodule
`default_nettype wire

// ---- verification/registered_cmd_buffer_parity_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module registered_cmd_buffer_parity_test;
  // ***************************************************
  // signals
  // ***************************************************
  typedef struct packed {logic [21:0] w; logic [1:0] sel; logic gate; logic ld;} row_type;
  logic        clk = 1'b0;      // 200 MHz
  logic        rst_n = 1'b1;    // async, active low; falls just after time zero
  logic        gate = 1'b0;     // gated capture enable
  logic        bad = 1'b0;      // inject wrong parity
  logic        rdy = 1'b0;      // log drain ready
  logic [21:0] word = 22'h000000;
  logic [1:0]  sel = 2'h3;      // {sel1_n, sel0_n}
  logic [21:0] exp_cmd = 22'h000000;  // what both banks should hold
  wire  logic [21:0] cmd, qa, qb, ldat;
  wire  logic        s0_n, s1_n, par, fn, lv, drop;
  wire  logic [1:0]  sa, sb, ca, cb, oa, ob;
  int          num_errors = 0;
  int          comparisons = 0;
  // ordinary cases: inputs beside the load they should cause
  localparam row_type rows [6] = '{
    '{22'h2aaaaa, 2'h2, 1'b1, 1'b1},  // select 0 low
    '{22'h155555, 2'h1, 1'b1, 1'b1},  // select 1 low
    '{22'h3fffff, 2'h0, 1'b1, 1'b1},  // both low
    '{22'h0f0f0f, 2'h3, 1'b1, 1'b0},  // gated, none selected: hold
    '{22'h123456, 2'h3, 1'b0, 1'b1},  // ungated: load anyway
    '{22'h000001, 2'h3, 1'b1, 1'b0}}; // hold again

  // ***************************************************
  // clock, partner and design
  // ***************************************************
  initial forever #2.5 clk = ~clk;
  cmd_ctrl_model cmd_ctrl_model_i (.i_clk_sys(clk), .i_word(word), .i_sel_n(sel), .i_bad(bad),
    .o_cmd(cmd), .o_sel0_n(s0_n), .o_sel1_n(s1_n), .o_par(par));
  // cke and odt ride on low word bits so they change with the word
  registered_cmd_buffer_parity #(.CMD_W(22), .LOG_DEPTH(8)) registered_cmd_buffer_parity_i (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_cmd_addr_in(cmd), .i_parity_bit_in(par),
    .i_rank_select0_n(s0_n), .i_rank_select1_n(s1_n), .i_dram_clk_enable_in(word[1:0]),
    .i_dram_termination_in(word[3:2]), .i_select_gated_capture_en(gate),
    .o_cmd_addr_out_bank_a(qa), .o_rank_select_out_a(sa), .o_cke_out_a(ca), .o_odt_out_a(oa),
    .o_cmd_addr_out_bank_b(qb), .o_rank_select_out_b(sb), .o_cke_out_b(cb), .o_odt_out_b(ob),
    .o_parity_fault_n(fn), .o_log_valid(lv), .i_log_ready(rdy), .o_log_data(ldat),
    .o_log_dropped(drop));

  // ***************************************************
  // tasks
  // ***************************************************
  // one comparison; four-state so an unknown never matches
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one cycle of traffic, then the redriven banks are compared
  task automatic step(input logic [21:0] w, input logic [1:0] s, input logic g, input logic b,
                      input logic ld);
    @(negedge clk);
    word <= w;
    sel  <= s;
    gate <= g;
    bad  <= b;
    @(posedge clk);
    #1;
    if (ld) exp_cmd = w;
    check("bank_a", qa, exp_cmd);
    check("bank_b", qb, exp_cmd);
    check("sel_out", {sa, sb}, {s, s});
    check("cke_odt", {ca, cb, oa, ob}, {w[1:0], w[1:0], w[3:2], w[3:2]});
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 200 cycles
  initial begin
    #5000;
    num_errors++;
    results();
  end

  // ***************************************************
  // sequence
  // ***************************************************
  initial begin
    // a real falling edge, so the flops clear before the first clock edge
    #1;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check("reset_bank", {qa, sa, ca, oa}, 32'h0);
    check("reset_fault", fn, 1'b1);
    @(negedge clk);
    rst_n <= 1'b1;
    // table of ordinary captures
    foreach (rows[i]) begin
      step(rows[i].w, rows[i].sel, rows[i].gate, 1'b0, rows[i].ld);
      check("fault_idle", fn, 1'b1);
    end
    $display("capture table done");
    // mismatch: fault falls one edge after its parity edge, low two cycles
    step(22'h00abcd, 2'h2, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      step(22'h000003, 2'h2, 1'b1, 1'b0, 1'b1);
      check("fault_n", fn, (5'b11001 >> i) & 1);
      if (i == 0) check("log_push", {lv, ldat}, {1'b1, 22'h00abcd});
    end
    // no select low: bad parity unchecked, gate setting ignored
    step(22'h000007, 2'h3, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      step(22'h000003, 2'h3, 1'b1, 1'b0, 1'b0);
      check("fault_unsel", fn, 1'b1);
    end
    $display("parity timing done");
    // back-to-back mismatches overrun the log while drain stalls
    for (int i = 0; i < 9; i++) step(22'(22'h000100 + i), 2'h1, 1'b1, 1'b1, 1'b1);
    step(22'h000000, 2'h1, 1'b1, 1'b0, 1'b1);
    step(22'h000000, 2'h1, 1'b1, 1'b0, 1'b1);
    check("fault_retrig", fn, 1'b0);
    check("log_dropped", drop, 1'b1);
    // drain in order, stalling a cycle between pops
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      rdy <= 1'b0;
      @(negedge clk);
      check("log_valid", lv, 1'b1);
      check("log_data", ldat, (i == 0) ? 32'h00abcd : 32'h000100 + i - 1);
      rdy <= 1'b1;
    end
    @(negedge clk);
    rdy <= 1'b0;
    check("log_empty", lv, 1'b0);
    $display("log fill and drain done");
    // reset mid-fault acts with no clock edge in between
    step(22'h00abcd, 2'h2, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) step(22'h000003, 2'h2, 1'b1, 1'b0, 1'b1);
    check("fault_before_reset", fn, 1'b0);
    @(negedge clk);
    rst_n <= 1'b0;
    #1;
    exp_cmd = 22'h000000;
    check("async_bank", {qb, sb, cb, ob}, 32'h0);
    check("async_fault", {fn, drop}, 2'b10);
    @(negedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      step(22'h000003, 2'h2, 1'b1, 1'b0, 1'b1);
      check("fault_cleared", fn, 1'b1);
    end
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire

// ---- verilog/cmd_buffer_pkg.sv ----
`default_nettype none
package cmd_buffer_pkg;
  // ***************************************************
  // widths and depths
  // ***************************************************
  localparam int CMD_W      = 22;  // command/address lines
  localparam int SEL_W      = 2;   // rank selects
  localparam int CKE_W      = 2;   // dram clock enables
  localparam int ODT_W      = 2;   // dram termination lines
  localparam int LOG_DEPTH  = 8;   // fault log words

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [CMD_W-1:0] CMD_RST     = 22'h000000;
  localparam logic             FAULT_N_RST = 1'b1;  // idles high
  localparam logic             CHK_RST     = 1'b0;

  // ***************************************************
  // carriers
  // ***************************************************
  // redriven side-band lines of one bank
  typedef struct packed {
    logic [SEL_W-1:0] select_n;
    logic [CKE_W-1:0] cke;
    logic [ODT_W-1:0] odt;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = '{select_n: 2'h0, cke: 2'h0, odt: 2'h0};

  // fault output sequencer: two low cycles then idle
  typedef enum logic [1:0] {
    FAULT_IDLE   = 2'b00,
    FAULT_LOW_1  = 2'b01,
    FAULT_LOW_2  = 2'b10
  } fault_state_type;
endpackage
`default_nettype wire

// ---- verilog/registered_cmd_buffer_parity.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// fault log fifo
// ***************************************************
module fault_log_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fault_log_fifo: depth must be a power of two");
    end
  end

  // whole fifo state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type st_q;  // registered state
  fifo_state_type st_d;  // next state
  logic           push;  // accepted write
  logic           pop;   // accepted read

  // honest flags from the occupancy count
  assign o_in_ready  = (st_q.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_q.count != '0);
  assign o_out_data  = st_q.mem[st_q.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // next-state logic
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = i_in_data;
      st_d.wr_ptr           = st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
    // count moves only when exactly one side acts
    case ({push, pop})
      2'b10:   st_d.count = st_q.count + 1'b1;
      2'b01:   st_d.count = st_q.count - 1'b1;
      default: st_d.count = st_q.count;
    endcase
  end

  // state register, cleared with the buffer reset
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ***************************************************
// registered 1:2 command buffer with parity check
// ***************************************************
module registered_cmd_buffer_parity #(
  parameter int CMD_W     = 22,
  parameter int LOG_DEPTH = 8
) (
  // clock and asynchronous reset
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_reset_n,
  // command/address from the controller
  input  wire logic [CMD_W-1:0]                     i_cmd_addr_in,
  input  wire logic                                 i_parity_bit_in,
  input  wire logic                                 i_rank_select0_n,
  input  wire logic                                 i_rank_select1_n,
  input  wire logic [cmd_buffer_pkg::CKE_W-1:0]     i_dram_clk_enable_in,
  input  wire logic [cmd_buffer_pkg::ODT_W-1:0]     i_dram_termination_in,
  // program input
  input  wire logic                                 i_select_gated_capture_en,
  // redriven bank a
  output logic [CMD_W-1:0]                          o_cmd_addr_out_bank_a,
  output logic [cmd_buffer_pkg::SEL_W-1:0]          o_rank_select_out_a,
  output logic [cmd_buffer_pkg::CKE_W-1:0]          o_cke_out_a,
  output logic [cmd_buffer_pkg::ODT_W-1:0]          o_odt_out_a,
  // redriven bank b
  output logic [CMD_W-1:0]                          o_cmd_addr_out_bank_b,
  output logic [cmd_buffer_pkg::SEL_W-1:0]          o_rank_select_out_b,
  output logic [cmd_buffer_pkg::CKE_W-1:0]          o_cke_out_b,
  output logic [cmd_buffer_pkg::ODT_W-1:0]          o_odt_out_b,
  // parity fault, active low
  output logic                                      o_parity_fault_n,
  // fault log of offending command words
  output logic                                      o_log_valid,
  input  wire logic                                 i_log_ready,
  output logic [CMD_W-1:0]                          o_log_data,
  output logic                                      o_log_dropped
);
  initial begin
    if (CMD_W != cmd_buffer_pkg::CMD_W || LOG_DEPTH != cmd_buffer_pkg::LOG_DEPTH) begin
      $error("registered_cmd_buffer_parity: widths fixed by the package");
    end
  end

  // whole block state in one struct
  typedef struct packed {
    logic [CMD_W-1:0]                cmd_a;     // bank a command lines
    logic [CMD_W-1:0]                cmd_b;     // bank b command lines
    cmd_buffer_pkg::ctrl_type        ctrl_a;    // bank a side-band
    cmd_buffer_pkg::ctrl_type        ctrl_b;    // bank b side-band
    logic [CMD_W-1:0]                cmd_prev;  // word awaiting its parity bit
    logic                            chk_prev;  // that word had a select low
    logic                            mism;      // compare result, one stage
    cmd_buffer_pkg::fault_state_type fault_st;  // low-pulse sequencer
    logic                            fault_n;   // output flop
    logic                            dropped;   // sticky log overflow
  } state_type;

  localparam state_type STATE_RST = '{
    cmd_a:    cmd_buffer_pkg::CMD_RST,
    cmd_b:    cmd_buffer_pkg::CMD_RST,
    ctrl_a:   cmd_buffer_pkg::CTRL_RST,
    ctrl_b:   cmd_buffer_pkg::CTRL_RST,
    cmd_prev: cmd_buffer_pkg::CMD_RST,
    chk_prev: cmd_buffer_pkg::CHK_RST,
    mism:     1'b0,
    fault_st: cmd_buffer_pkg::FAULT_IDLE,
    fault_n:  cmd_buffer_pkg::FAULT_N_RST,
    dropped:  1'b0
  };

  state_type                st_q;        // registered state
  state_type                st_d;        // next state
  logic                     sel_active;  // at least one select low now
  logic                     capture;     // command lines load this edge
  logic                     mismatch;    // parity compare this edge
  logic                     log_ready;   // fifo can take a word
  cmd_buffer_pkg::ctrl_type ctrl_in;     // side-band inputs bundled

  // even parity: xor of word and parity bit must be zero
  function automatic logic parity_bad(input logic [CMD_W-1:0] word, input logic par);
    parity_bad = ^{word, par};
  endfunction

  assign sel_active = !i_rank_select0_n || !i_rank_select1_n;
  // gated mode holds the lines while no rank is addressed
  assign capture    = !i_select_gated_capture_en || sel_active;
  // parity arrives one edge late, so compare with the stored word
  assign mismatch   = st_q.chk_prev && parity_bad(st_q.cmd_prev, i_parity_bit_in);
  assign ctrl_in    = '{select_n: {i_rank_select1_n, i_rank_select0_n},
                        cke: i_dram_clk_enable_in, odt: i_dram_termination_in};

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    st_d = st_q;
    // command lines, same word on both banks
    if (capture) begin
      st_d.cmd_a = i_cmd_addr_in;
      st_d.cmd_b = i_cmd_addr_in;
    end
    // side-band lines ignore the gating mode
    st_d.ctrl_a = ctrl_in;
    st_d.ctrl_b = ctrl_in;
    // parity pipeline: check every word with a select low, whatever the gating mode
    st_d.cmd_prev = i_cmd_addr_in;
    st_d.chk_prev = sel_active;
    st_d.mism     = mismatch;
    // extra stage between compare and pin
    case (st_q.fault_st)
      cmd_buffer_pkg::FAULT_IDLE: begin
        if (st_q.mism) begin
          st_d.fault_st = cmd_buffer_pkg::FAULT_LOW_1;
        end
      end
      cmd_buffer_pkg::FAULT_LOW_1: begin
        st_d.fault_st = st_q.mism ? cmd_buffer_pkg::FAULT_LOW_1 : cmd_buffer_pkg::FAULT_LOW_2;
      end
      cmd_buffer_pkg::FAULT_LOW_2: begin
        // a fresh error restarts the two-cycle window
        st_d.fault_st = st_q.mism ? cmd_buffer_pkg::FAULT_LOW_1 : cmd_buffer_pkg::FAULT_IDLE;
      end
      default: begin
        st_d.fault_st = cmd_buffer_pkg::FAULT_IDLE;
      end
    endcase
    st_d.fault_n = (st_d.fault_st == cmd_buffer_pkg::FAULT_IDLE);
    // the log never stalls the buffer; losses are flagged instead
    if (mismatch && !log_ready) begin
      st_d.dropped = 1'b1;
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  // reset acts at once, without a clock edge
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // fault log
  // ***************************************************
  // keeps each mismatching word that finds room for later diagnosis
  fault_log_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (LOG_DEPTH)
  ) fault_log_fifo_i (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (mismatch),
    .o_in_ready  (log_ready),
    .i_in_data   (st_q.cmd_prev),
    .o_out_valid (o_log_valid),
    .i_out_ready (i_log_ready),
    .o_out_data  (o_log_data)
  );

  // outputs straight from the state flops
  assign o_cmd_addr_out_bank_a = st_q.cmd_a;
  assign o_cmd_addr_out_bank_b = st_q.cmd_b;
  assign o_rank_select_out_a   = st_q.ctrl_a.select_n;
  assign o_cke_out_a           = st_q.ctrl_a.cke;
  assign o_odt_out_a           = st_q.ctrl_a.odt;
  assign o_rank_select_out_b   = st_q.ctrl_b.select_n;
  assign o_cke_out_b           = st_q.ctrl_b.cke;
  assign o_odt_out_b           = st_q.ctrl_b.odt;
  assign o_parity_fault_n      = st_q.fault_n;
  assign o_log_dropped         = st_q.dropped;

  // ***************************************************
  // assertions
  // ***************************************************
  // sampled values: a pin seen at an edge was set by the edge before
  a_gated_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_select_gated_capture_en && i_rank_select0_n && i_rank_select1_n) |=> $stable(o_cmd_addr_out_bank_a))
    else $error("gated capture did not hold");
  a_gated_load: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_select_gated_capture_en && !i_rank_select0_n) |=> o_cmd_addr_out_bank_a == $past(i_cmd_addr_in))
    else $error("gated capture missed a selected word");
  a_open_load: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_select_gated_capture_en |=> o_cmd_addr_out_bank_a == $past(i_cmd_addr_in))
    else $error("ungated capture missed a word");
  a_banks_equal: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_cmd_addr_out_bank_a == o_cmd_addr_out_bank_b && o_rank_select_out_a == o_rank_select_out_b)
    else $error("banks differ");
  a_sideband_load: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    1'b1 |=> o_cke_out_b == $past(i_dram_clk_enable_in) && o_odt_out_a == $past(i_dram_termination_in)
      && o_rank_select_out_b == $past({i_rank_select1_n, i_rank_select0_n}))
    else $error("side-band lines not registered");
  // back-to-back mismatches keep the pin low, so only the low edge is fixed here
  a_fault_timing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_q.chk_prev && parity_bad(st_q.cmd_prev, i_parity_bit_in)) |-> ##2 !o_parity_fault_n)
    else $error("fault output not low two edges after a mismatch");
  // from idle the pin must wait out the extra stage before falling
  a_fault_delay: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_q.chk_prev && parity_bad(st_q.cmd_prev, i_parity_bit_in) && o_parity_fault_n && !st_q.mism)
      |-> ##1 o_parity_fault_n)
    else $error("fault output fell before its delay stage");
  a_fault_width: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(o_parity_fault_n) |-> !o_parity_fault_n [*2])
    else $error("fault output shorter than two cycles");
  a_fault_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (!st_q.mism && !$past(st_q.mism) && !$past(st_q.mism, 2)) |-> o_parity_fault_n)
    else $error("fault output low without a mismatch");
  a_reset_outputs: assert property (@(posedge i_clk_sys)
    !i_reset_n |-> o_cmd_addr_out_bank_a == '0 && o_cke_out_b == '0 && o_parity_fault_n && !st_q.mism)
    else $error("reset did not clear the buffer");

  // main scenarios the bench should reach
  c_gated_hold: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_select_gated_capture_en && i_rank_select0_n && i_rank_select1_n && i_cmd_addr_in != o_cmd_addr_out_bank_a);
  c_fault_pulse: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(o_parity_fault_n) ##2 o_parity_fault_n);
  c_log_drop: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) $rose(o_log_dropped));
  c_fault_retrig: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !o_parity_fault_n && st_q.mism);
  c_open_load: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_select_gated_capture_en && i_rank_select0_n && i_rank_select1_n);
endmodule
`default_nettype wire
